// [rtl/reset_strap_capture_decode.sv]
// Strap capture at reset release and decode of settings
//
// Decided for this implementation: the address-and-strobe port and the address map.
`include "strap_cfg.svh"
module reset_strap_capture_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] mgmt_addr_strap,
    input wire logic broadcast_addr_strap,
    input wire logic [3:0] mode_strap,
    input wire logic refclk_out_enable_strap,
    input wire logic led_style_strap,
    input wire logic [4:0] mgmt_txn_addr,
    input wire logic mgmt_txn_valid,
    input wire logic broadcast_wr_en,
    input wire logic broadcast_wr_data,
    input wire logic refclk_sel_recovered,
    output logic [4:0] mgmt_addr,
    output logic broadcast_addr_enable_bit,
    output logic mgmt_addr_match,
    output strap_pkg::dev_mode_t dev_mode,
    output logic adv_1000_full,
    output logic adv_1000_half,
    output logic adv_10_100_full,
    output logic adv_10_100_half,
    output logic nand_tree_mode,
    output logic power_down_mode,
    output logic mode_reserved,
    output logic wake_on_indicator,
    output logic wake_on_irq_pin,
    output logic refclk_out_enable,
    output logic refclk_out_recovered,
    output logic led_individual_mode
);

    // ==========================================================
    // Reset release and strap synchronisers
    logic rst_meta, rst_sync;
    logic [9:0] strap_meta, strap_sync;
    logic captured;
    logic next_captured;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 10'h000;
            strap_sync <= 10'h000;
        end else begin
            strap_meta <= {mgmt_addr_strap, broadcast_addr_strap, mode_strap,
                           refclk_out_enable_strap, led_style_strap};
            strap_sync <= strap_meta;
        end
    end

    // ==========================================================
    // One-shot capture after release
    logic [2:0] addr_lo, next_addr_lo;
    logic bcast_strap_q, next_bcast_strap_q;
    logic [3:0] mode_q, next_mode_q;
    logic clk_en_q, next_clk_en_q;
    logic led_q, next_led_q;
    logic bcast_en, next_bcast_en;

    // Straps settle by board design; sampled once, later changes ignored
    always_comb begin
        next_captured = captured;
        next_addr_lo = addr_lo;
        next_bcast_strap_q = bcast_strap_q;
        next_mode_q = mode_q;
        next_clk_en_q = clk_en_q;
        next_led_q = led_q;
        next_bcast_en = bcast_en;
        if (!captured) begin
            next_captured = 1'b1;
            {next_addr_lo, next_bcast_strap_q, next_mode_q, next_clk_en_q, next_led_q} = strap_sync;
            next_bcast_en = ~strap_sync[6];
        end else if (broadcast_wr_en) begin
            next_bcast_en = broadcast_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            captured <= 1'b0;
            addr_lo <= 3'h0;
            bcast_strap_q <= 1'b0;
            mode_q <= 4'h0;
            clk_en_q <= 1'b0;
            led_q <= 1'b0;
            bcast_en <= 1'b0;
        end else begin
            captured <= next_captured;
            addr_lo <= next_addr_lo;
            bcast_strap_q <= next_bcast_strap_q;
            mode_q <= next_mode_q;
            clk_en_q <= next_clk_en_q;
            led_q <= next_led_q;
            bcast_en <= next_bcast_en;
        end
    end

    // ==========================================================
    // Decode, registered onto outputs
    strap_pkg::dev_mode_t next_dev_mode;
    logic [3:0] next_adv;
    logic next_match;

    always_comb begin
        next_adv = 4'h0;
        case (mode_q)
            `MODE_RMII_LED: begin
                next_dev_mode = strap_pkg::MODE_RGMII_LED_WAKE;
                next_adv = 4'h3;
            end
            `MODE_RMII_IRQ: begin
                next_dev_mode = strap_pkg::MODE_RGMII_IRQ_WAKE;
                next_adv = 4'h3;
            end
            `MODE_GIG_ONLY: begin
                next_dev_mode = strap_pkg::MODE_RGMII_GIG_ONLY;
                next_adv = 4'h8;
            end
            `MODE_GIG_ALL: begin
                next_dev_mode = strap_pkg::MODE_RGMII_GIG_ALL;
                next_adv = 4'hB;
            end
            `MODE_NAND_TREE: next_dev_mode = strap_pkg::MODE_NAND_TREE;
            `MODE_POWER_DOWN: next_dev_mode = strap_pkg::MODE_POWER_DOWN;
            default: next_dev_mode = strap_pkg::MODE_RESERVED;
        endcase
        if (!captured) begin
            next_dev_mode = strap_pkg::MODE_RESERVED;
            next_adv = 4'h0;
        end
        // Own address always; address 0 too when broadcast enabled
        next_match = mgmt_txn_valid && captured &&
                     ((mgmt_txn_addr == {`MGMT_ADDR_HI, addr_lo}) ||
                      (bcast_en && mgmt_txn_addr == 5'h00));
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mgmt_addr <= 5'h00;
            broadcast_addr_enable_bit <= 1'b0;
            mgmt_addr_match <= 1'b0;
            dev_mode <= strap_pkg::MODE_RESERVED;
            adv_1000_full <= 1'b0;
            adv_1000_half <= 1'b0;
            adv_10_100_full <= 1'b0;
            adv_10_100_half <= 1'b0;
            nand_tree_mode <= 1'b0;
            power_down_mode <= 1'b0;
            mode_reserved <= 1'b0;
            wake_on_indicator <= 1'b0;
            wake_on_irq_pin <= 1'b0;
            refclk_out_enable <= 1'b0;
            refclk_out_recovered <= 1'b0;
            led_individual_mode <= 1'b0;
        end else begin
            mgmt_addr <= {`MGMT_ADDR_HI, addr_lo};
            broadcast_addr_enable_bit <= bcast_en;
            mgmt_addr_match <= next_match;
            dev_mode <= next_dev_mode;
            adv_1000_full <= next_adv[3];
            adv_1000_half <= next_adv[2];
            adv_10_100_full <= next_adv[1];
            adv_10_100_half <= next_adv[0];
            nand_tree_mode <= next_dev_mode == strap_pkg::MODE_NAND_TREE;
            power_down_mode <= next_dev_mode == strap_pkg::MODE_POWER_DOWN;
            mode_reserved <= captured && next_dev_mode == strap_pkg::MODE_RESERVED;
            wake_on_indicator <= next_dev_mode == strap_pkg::MODE_RGMII_LED_WAKE;
            wake_on_irq_pin <= next_dev_mode == strap_pkg::MODE_RGMII_IRQ_WAKE;
            refclk_out_enable <= captured && clk_en_q;
            refclk_out_recovered <= captured && clk_en_q && refclk_sel_recovered;
            led_individual_mode <= captured && led_q;
        end
    end

endmodule

// [rtl/strap_cfg.svh]
// Strap capture constants and the function list
// Function
// - All strap levels are caught when the chip reset is released and held until the next reset.
// - Three address straps form the low three management address bits, high giving 1 and low giving 0.
// - The two upper bits of the five-bit management address are always zero.
// - The caught address is the device's own management address, compared against every transaction.
// - A low broadcast strap makes the device answer at address 0 as well; a high one only at its own address.
// - The broadcast strap only sets the reset default of the broadcast enable bit, as its inverse.
// - Mode codes 1000 and 1010 advertise 10/100 only, 1100 only 1000 full, 1110 both 1000 full and 10/100.
// - No functional mode advertises 1000 Mb/s half duplex.
// - Mode code 0100 enters NAND tree test and 0111 powers the whole device down.
// - A high clock-output strap drives the reference clock out; a low one keeps the output disabled.
// - The clock output carries the local clock by default, with a selectable recovered receive clock.
// - A high LED strap selects individual-Led_style_strap, a low one tri-color-Led_style_strap.
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH
`define MGMT_ADDR_W 5
`define MGMT_ADDR_HI 2'h0
`define MODE_RMII_LED 4'h8
`define MODE_RMII_IRQ 4'hA
`define MODE_GIG_ONLY 4'hC
`define MODE_GIG_ALL 4'hE
`define MODE_NAND_TREE 4'h4
`define MODE_POWER_DOWN 4'h7
`endif

// [rtl/strap_pkg.sv]
// Types for the strap capture block
package strap_pkg;
    typedef enum logic [2:0] {
        MODE_RESERVED,
        MODE_RGMII_LED_WAKE,
        MODE_RGMII_IRQ_WAKE,
        MODE_RGMII_GIG_ONLY,
        MODE_RGMII_GIG_ALL,
        MODE_NAND_TREE,
        MODE_POWER_DOWN
    } dev_mode_t;
endpackage

// [verif/strap_checker.sv]
// Concurrent checks on the strap capture block ports
// ====================
// Checker
module strap_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] mgmt_addr,
    input wire logic [4:0] mgmt_txn_addr,
    input wire logic mgmt_txn_valid,
    input wire logic mgmt_addr_match,
    input wire logic broadcast_addr_enable_bit,
    input wire strap_pkg::dev_mode_t dev_mode,
    input wire logic adv_1000_full,
    input wire logic adv_1000_half,
    input wire logic adv_10_100_full,
    input wire logic nand_tree_mode,
    input wire logic power_down_mode,
    input wire logic mode_reserved,
    input wire logic refclk_out_enable,
    input wire logic refclk_sel_recovered,
    input wire logic refclk_out_recovered,
    input wire logic led_individual_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ADDR_HI: assert property (mgmt_addr[4:3] == 2'h0) else $error("upper address bits set");
    AST_NO_HALF: assert property (!adv_1000_half) else $error("gigabit half duplex advertised");
    AST_NO_MATCH: assert property (mgmt_txn_valid && $stable(mgmt_addr) && mgmt_txn_addr != mgmt_addr
        && !(mgmt_txn_addr == 5'h00 && broadcast_addr_enable_bit) |=> !mgmt_addr_match) else $error("false match");
    AST_BCAST: assert property (mgmt_txn_valid && mgmt_txn_addr == 5'h00 && broadcast_addr_enable_bit
        && $stable(broadcast_addr_enable_bit) |=> mgmt_addr_match) else $error("address zero not answered");
    AST_TEST: assert property (nand_tree_mode || power_down_mode |-> !adv_1000_full && !adv_10_100_full
        && !mode_reserved) else $error("test mode with advertisement");
    AST_RSVD: assert property (mode_reserved |-> dev_mode == strap_pkg::MODE_RESERVED && !adv_1000_full
        && !adv_10_100_full && !nand_tree_mode && !power_down_mode) else $error("reserved code acts");
    AST_GIG: assert property (adv_1000_full |-> dev_mode inside {strap_pkg::MODE_RGMII_GIG_ONLY,
        strap_pkg::MODE_RGMII_GIG_ALL}) else $error("gigabit advertised in wrong mode");
    AST_RECOV: assert property (refclk_out_enable && $past(refclk_out_enable) && refclk_sel_recovered
        |=> refclk_out_recovered) else $error("recovered clock not selected");
    AST_HOLD: assert property ($rose(led_individual_mode) |=> $stable(led_individual_mode) [*8])
        else $error("captured led style changed");
endmodule

bind reset_strap_capture_decode strap_checker chk (.*);

// [verif/strap_board.sv]
// Board strap resistor model
// ====================
// Board
module strap_board (
    input wire logic [9:0] cfg,
    input wire logic hold,
    output logic [2:0] mgmt_addr_strap,
    output logic broadcast_addr_strap,
    output logic [3:0] mode_strap,
    output logic refclk_out_enable_strap,
    output logic led_style_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shared pins carry other traffic once released, so levels move
    assign {mgmt_addr_strap, broadcast_addr_strap, mode_strap, refclk_out_enable_strap, led_style_strap} =
        hold ? cfg : ~cfg;
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the strap capture block
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
// ====================
// Bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, mgmt_txn_valid, broadcast_wr_en, broadcast_wr_data, refclk_sel_recovered, hold, bc;
    logic broadcast_addr_strap, refclk_out_enable_strap, led_style_strap, broadcast_addr_enable_bit, mgmt_addr_match;
    logic adv_1000_full, adv_1000_half, adv_10_100_full, adv_10_100_half, nand_tree_mode, power_down_mode;
    logic mode_reserved, wake_on_indicator, wake_on_irq_pin, refclk_out_enable, refclk_out_recovered;
    logic led_individual_mode;
    logic [2:0] mgmt_addr_strap;
    logic [3:0] mode_strap;
    logic [4:0] mgmt_txn_addr, mgmt_addr;
    logic [9:0] cfg;
    logic [31:0] r;
    strap_pkg::dev_mode_t dev_mode;
    int fails, check_count, cyc, seed, c;
    reset_strap_capture_decode uut (.*);
    strap_board board (.cfg(cfg), .hold(hold), .mgmt_addr_strap(mgmt_addr_strap),
        .broadcast_addr_strap(broadcast_addr_strap), .mode_strap(mode_strap),
        .refclk_out_enable_strap(refclk_out_enable_strap), .led_style_strap(led_style_strap));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            fails++;
            stop_test();
        end
    end
    function automatic strap_pkg::dev_mode_t emode(int m);
        case (m)
            8: return strap_pkg::MODE_RGMII_LED_WAKE;
            10: return strap_pkg::MODE_RGMII_IRQ_WAKE;
            12: return strap_pkg::MODE_RGMII_GIG_ONLY;
            14: return strap_pkg::MODE_RGMII_GIG_ALL;
            4: return strap_pkg::MODE_NAND_TREE;
            7: return strap_pkg::MODE_POWER_DOWN;
            default: return strap_pkg::MODE_RESERVED;
        endcase
    endfunction
    task automatic txn(logic [4:0] a);
        @(posedge clk) mgmt_txn_valid <= 1;
        mgmt_txn_addr <= a;
        @(posedge clk) mgmt_txn_valid <= 0;
        #1 `CHK("match", a == {2'h0, cfg[9:7]} || (a == 5'h00 && bc), mgmt_addr_match)
    endtask
    task automatic stop_test();
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        seed = 28592;
        {rst_n, mgmt_txn_valid, broadcast_wr_en, broadcast_wr_data, refclk_sel_recovered} = '0;
        {hold, mgmt_txn_addr, cfg} = {1'b1, 15'h0000};
        for (int i = 0; i < 20; i++) begin
            // All sixteen codes first, then random ones
            r = $random(seed);
            c = (i < 16) ? i : int'(r[9:6]);
            @(posedge clk) rst_n <= 0;
            hold <= 1;
            cfg <= {r[5:2], c[3:0], r[1:0]};
            repeat (8) @(posedge clk);
            rst_n <= 1;
            repeat (8) @(posedge clk);
            hold <= 0;
            repeat (3) @(posedge clk);
            #1 bc = ~cfg[6];
            `CHK("addr", {2'h0, cfg[9:7]}, mgmt_addr)
            `CHK("bcast", bc, broadcast_addr_enable_bit)
            `CHK("mode", emode(c), dev_mode)
            `CHK("adv", {c == 12 || c == 14, 1'b0, {2{c == 8 || c == 10 || c == 14}}},
                {adv_1000_full, adv_1000_half, adv_10_100_full, adv_10_100_half})
            `CHK("test", {c == 4, c == 7, emode(c) == strap_pkg::MODE_RESERVED},
                {nand_tree_mode, power_down_mode, mode_reserved})
            `CHK("wake", {c == 8, c == 10}, {wake_on_indicator, wake_on_irq_pin})
            `CHK("clkout", cfg[1], refclk_out_enable)
            `CHK("led", cfg[0], led_individual_mode)
            txn({2'h0, cfg[9:7]});
            txn(5'h00);
            txn(5'(r[31:27]));
            @(posedge clk) broadcast_wr_en <= 1;
            broadcast_wr_data <= ~bc;
            @(posedge clk) broadcast_wr_en <= 0;
            repeat (2) @(posedge clk);
            #1 bc = ~bc;
            `CHK("bcast_wr", bc, broadcast_addr_enable_bit)
            txn(5'h00);
            @(posedge clk) refclk_sel_recovered <= 1'b1;
            repeat (3) @(posedge clk);
            #1 `CHK("recov", cfg[1], refclk_out_recovered)
            @(posedge clk) refclk_sel_recovered <= 1'b0;
        end
        stop_test();
    end
endmodule
